// *** core/clock_calendar_unit_cfg_top.sv ***
// APB front end of the configuration and calibration register.
// Assumes presetn is the power-on reset and pclk the reference.
`timescale 1ns/1ns
`default_nettype none
module clock_calendar_unit_cfg_top
    import clock_calendar_unit_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = HALF_SEC_CYC
) (
    input wire logic        pclk,       // Clock
    input wire logic        presetn,    // Power-on reset, low
    input wire logic        psel,       // APB select
    input wire logic        penable,    // APB access phase
    input wire logic        pwrite,     // APB write
    input wire logic [7:0]  paddr,      // APB byte address
    input wire logic [31:0] pwdata,     // APB write data
    input wire logic [3:0]  pstrb,      // APB byte strobes
    output logic [31:0]     prdata,     // APB read data
    output logic            pready,     // APB ready
    output logic            pslverr,    // APB error
    output logic            irq,        // Interrupt level
    output logic            clk_out,    // Clock output pin
    output logic            module_run  // Enable state
);
    // --------------------------------------------------------------
    // Register state
    // --------------------------------------------------------------
    logic        clock_module_enable;
    logic        value_write_unlock;
    logic        rollover_pending_flag;
    logic        half_second_flag;
    logic        clock_pin_output_enable;
    logic [1:0]  value_window_select;
    logic [7:0]  cal;
    logic [15:0] rtc_config_trim_reg;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_enable;
    logic [EVT_W-1:0] evt_set;
    logic        key_first_seen;
    logic [3:0]  key_window;
    logic        near_roll_d;
    logic        half_tick;
    logic        min_tick;
    logic        near_roll;

    clock_calendar_unit_win_if win ();

    function automatic logic is_mapped(input logic [7:0] a);
        return a == OFS_CFG || a == OFS_WINDOW || a == OFS_KEY
            || a == OFS_STATUS || a == OFS_CLEAR || a == OFS_ENABLE;
    endfunction : is_mapped

    // --------------------------------------------------------------
    // Bus decode
    // --------------------------------------------------------------
    logic done;
    logic wr_cfg;
    logic wr_win;
    logic rd_win;
    logic wr_key;
    logic wr_clr;
    logic wr_ena;
    logic unlock_ok;

    assign done   = psel && penable && pready;
    assign wr_cfg = done && pwrite && paddr == OFS_CFG;
    assign wr_win = done && pwrite && paddr == OFS_WINDOW;
    assign rd_win = done && !pwrite && paddr == OFS_WINDOW;
    assign wr_key = done && pwrite && paddr == OFS_KEY;
    assign wr_clr = done && pwrite && paddr == OFS_CLEAR;
    assign wr_ena = done && pwrite && paddr == OFS_ENABLE;
    assign unlock_ok = key_window != 4'h0;

    assign rtc_config_trim_reg = {clock_module_enable, 1'b0,
                                  value_write_unlock, rollover_pending_flag,
                                  half_second_flag, clock_pin_output_enable,
                                  value_window_select, cal};

    // Ready one cycle after setup; every access takes two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(paddr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_CFG:    prdata <= {16'h0, rtc_config_trim_reg};
                OFS_WINDOW: prdata <= {16'h0, win.rdata};
                OFS_STATUS: prdata <= {{(32 - EVT_W){1'b0}}, evt_status};
                OFS_ENABLE: prdata <= {{(32 - EVT_W){1'b0}}, evt_enable};
                default:    prdata <= 32'h0;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Unlock key sequence
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_first_seen <= 1'b0;
            key_window     <= 4'h0;
        end else begin
            if (wr_key) begin
                key_first_seen <= pwdata[7:0] == KEY_FIRST;
            end
            // Short window so a stray later write cannot unlock
            if (wr_key && key_first_seen && pwdata[7:0] == KEY_SECOND) begin
                key_window <= 4'(KEY_WINDOW_CYC);
            end else if (key_window != 4'h0) begin
                key_window <= key_window - 4'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Configuration fields, reset only by power-on
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_write_unlock <= CFG_RESET[BIT_UNLOCK];
        end else if (wr_cfg && pstrb[1]) begin
            if (!pwdata[BIT_UNLOCK]) begin
                value_write_unlock <= 1'b0;
            end else if (unlock_ok) begin
                value_write_unlock <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_module_enable <= CFG_RESET[BIT_EN];
        end else if (wr_cfg && pstrb[1] && value_write_unlock) begin
            clock_module_enable <= pwdata[BIT_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_pin_output_enable <= CFG_RESET[BIT_OE];
            cal                     <= CFG_RESET[7:0];
        end else if (wr_cfg) begin
            if (pstrb[1]) begin
                clock_pin_output_enable <= pwdata[BIT_OE];
            end
            if (pstrb[0]) begin
                cal <= pwdata[7:0];
            end
        end
    end

    // Pointer: a field write wins over a decrement, never both at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_window_select <= CFG_RESET[PTR_LSB +: 2];
        end else if (wr_cfg && pstrb[1]) begin
            value_window_select <= pwdata[PTR_LSB +: 2];
        end else if ((rd_win || (wr_win && pstrb[1]))
                     && value_window_select != PTR_MIN) begin
            value_window_select <= value_window_select - 2'h1;
        end
    end

    // Status bits ignore configuration writes; a low window write at pointer 00 clears bit 11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_second_flag      <= CFG_RESET[BIT_HALF];
            rollover_pending_flag <= CFG_RESET[BIT_ROLL];
        end else begin
            rollover_pending_flag <= near_roll;
            if (win.wr_lo && value_window_select == PTR_MIN) begin
                half_second_flag <= 1'b0;
            end else if (half_tick) begin
                half_second_flag <= !half_second_flag;
            end
        end
    end

    // --------------------------------------------------------------
    // Window and tick source
    // --------------------------------------------------------------
    assign win.ptr   = value_window_select;
    assign win.wdata = pwdata[15:0];
    assign win.wr_lo = wr_win && pstrb[0] && value_write_unlock;
    assign win.wr_hi = wr_win && pstrb[1] && value_write_unlock;

    clock_calendar_unit_value_store u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .win     (win)
    );

    clock_calendar_unit_tick_gen #(.HALF_CYCLES(HALF_CYCLES)) u_tick (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (clock_module_enable),
        .cal       (cal),
        .half_tick (half_tick),
        .min_tick  (min_tick),
        .near_roll (near_roll)
    );

    // --------------------------------------------------------------
    // Outputs and interrupts
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out    <= 1'b0;
            module_run <= 1'b0;
        end else begin
            clk_out    <= clock_pin_output_enable && clock_module_enable
                          && half_second_flag;
            module_run <= clock_module_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            near_roll_d <= 1'b0;
        end else begin
            near_roll_d <= near_roll;
        end
    end

    assign evt_set[EVT_HALF] = half_tick;
    assign evt_set[EVT_MIN]  = min_tick;
    assign evt_set[EVT_ROLL] = near_roll && !near_roll_d;

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status <= '0;
            evt_enable <= '0;
            irq        <= 1'b0;
        end else begin
            evt_status <= (evt_status & ~(wr_clr ? pwdata[EVT_W-1:0] : '0)) | evt_set;
            if (wr_ena) begin
                evt_enable <= pwdata[EVT_W-1:0];
            end
            irq <= |(evt_status & evt_enable);
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    a_en_locked: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cfg && !value_write_unlock |=> $stable(clock_module_enable))
        else $error("enable changed while locked");
    a_win_locked: assert property (@(posedge pclk) disable iff (!presetn)
        wr_win && !value_write_unlock |-> !win.wr_lo && !win.wr_hi)
        else $error("window written while locked");
    a_roll_follow: assert property (@(posedge pclk) disable iff (!presetn)
        near_roll |=> rollover_pending_flag)
        else $error("rollover flag missed");
    a_half_clear: assert property (@(posedge pclk) disable iff (!presetn)
        win.wr_lo && value_window_select == PTR_MIN |=> !half_second_flag)
        else $error("half flag not cleared");
    a_half_toggle: assert property (@(posedge pclk) disable iff (!presetn)
        half_tick && !win.wr_lo |=> half_second_flag != $past(half_second_flag))
        else $error("half flag not toggled");
    a_ptr_dec: assert property (@(posedge pclk) disable iff (!presetn)
        rd_win && value_window_select != PTR_MIN
        |=> value_window_select == $past(value_window_select) - 2'h1)
        else $error("pointer not decremented");
    a_ptr_floor: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_win || wr_win) && !wr_cfg && value_window_select == PTR_MIN
        |=> value_window_select == PTR_MIN)
        else $error("pointer went below zero");
    a_bit14_zero: assert property (@(posedge pclk) disable iff (!presetn)
        done && !pwrite && paddr == OFS_CFG |-> !prdata[14])
        else $error("bit 14 read as one");
    a_unlock_key: assert property (@(posedge pclk) disable iff (!presetn)
        !value_write_unlock && !unlock_ok |=> !value_write_unlock)
        else $error("unlock set without key");
    a_clk_pin: assert property (@(posedge pclk) disable iff (!presetn)
        !clock_pin_output_enable |=> !clk_out)
        else $error("clock pin driven while disabled");
    a_run_stop: assert property (@(posedge pclk) disable iff (!presetn)
        !clock_module_enable |=> !half_tick)
        else $error("tick while disabled");

    // --------------------------------------------------------------
    // Field write checks, one lane at a time
    // --------------------------------------------------------------
    a_en_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cfg && pstrb[1] && value_write_unlock |=> clock_module_enable == $past(pwdata[BIT_EN]))
        else $error("enable write lost while unlocked");
    a_oe_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cfg && pstrb[1] |=> clock_pin_output_enable == $past(pwdata[BIT_OE]))
        else $error("output enable write lost");
    a_ptr_set: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cfg && pstrb[1] |=> value_window_select == $past(pwdata[PTR_LSB +: 2]))
        else $error("pointer write lost");
    a_ptr_hi_dec: assert property (@(posedge pclk) disable iff (!presetn)
        wr_win && pstrb[1] && value_window_select != PTR_MIN
        |=> value_window_select == $past(value_window_select) - 2'h1)
        else $error("pointer not decremented on high write");
    a_cal_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cfg && pstrb[0] |=> cal == $past(pwdata[7:0]))
        else $error("calibration write lost");
    // Set beats a same-cycle clear, so a tick is never lost
    a_half_event: assert property (@(posedge pclk) disable iff (!presetn)
        half_tick |=> evt_status[EVT_HALF])
        else $error("half tick not recorded");
endmodule : clock_calendar_unit_cfg_top
`default_nettype wire

// *** core/clock_calendar_unit_pkg.sv ***
// Constants for the clock configuration and value window block.
// Assumes one 100 MHz clock that also serves as the reference clock.
// --------------------------------------------------------------------
// Overview of operation
// - Enable bit 15 runs the clock
// - Enable writes need unlock bit set
// - Unlock bit 13 gates window writes
// - Bit 12 flags possible rollover ripple
// - Bit 11 shows which half-second
// - Low minutes-seconds write clears bit 11
// - Bit 10 drives clock output pin
// - High window access decrements pointer to 00
// - Pointer selects minutes, weekday, month, reserved
// - Pointer selects seconds, hours, day, year
// - Only power-on reset clears the register
// - Eight-bit calibration field, bits 7..0
// - Bit 14 reads zero, ignores writes
// - Signed calibration, four pulses per step
// - Any window read decrements pointer
// - Unlock set only right after key
// --------------------------------------------------------------------
package clock_calendar_unit_pkg;
    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_WINDOW = 8'h04;
    localparam logic [7:0] OFS_KEY    = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CLEAR  = 8'h10;
    localparam logic [7:0] OFS_ENABLE = 8'h14;
    localparam int BIT_EN     = 15;
    localparam int BIT_UNLOCK = 13;
    localparam int BIT_ROLL   = 12;
    localparam int BIT_HALF   = 11;
    localparam int BIT_OE     = 10;
    localparam int PTR_LSB    = 8;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [1:0]  PTR_MIN   = 2'h0;
    localparam logic [7:0]  KEY_FIRST  = 8'h55;
    localparam logic [7:0]  KEY_SECOND = 8'hAA;
    localparam int EVT_W    = 3;
    localparam int EVT_HALF = 0;
    localparam int EVT_MIN  = 1;
    localparam int EVT_ROLL = 2;
    localparam int CLK_MHZ        = 100;
    localparam int HALF_SEC_MS    = 500;
    localparam int HALF_SEC_CYC   = HALF_SEC_MS * 1000 * CLK_MHZ;
    localparam int KEY_WINDOW_NS  = 40;
    localparam int KEY_WINDOW_CYC = (KEY_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int ROLL_WIN_NS    = 320;
    localparam int ROLL_WIN_CYC   = (ROLL_WIN_NS * CLK_MHZ) / 1000;
    localparam int HALVES_PER_MIN = 120;
    localparam int CAL_SHIFT      = 2;  // 4 pulses per step
endpackage : clock_calendar_unit_pkg

// *** core/clock_calendar_unit_tick_gen.sv ***
// Half-second tick source with once-a-minute drift trim.
// Assumes pclk is the reference clock.
`timescale 1ns/1ns
`default_nettype none
module clock_calendar_unit_tick_gen
    import clock_calendar_unit_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = HALF_SEC_CYC
) (
    input wire logic        pclk,      // Clock
    input wire logic        presetn,   // Power-on reset
    input wire logic        run,       // Module enabled
    input wire logic [7:0]  cal,       // Signed trim steps
    output logic            half_tick, // Half-second pulse
    output logic            min_tick,  // Minute pulse
    output logic            near_roll  // Rollover close
);
    logic [31:0] cnt;
    logic [31:0] limit;
    logic [6:0]  halves;
    logic        last_half;

    assign last_half = (halves == 7'(HALVES_PER_MIN - 1));

    always_comb begin
        limit = HALF_CYCLES;
        if (last_half) begin
            limit = HALF_CYCLES + ({{24{cal[7]}}, cal} << CAL_SHIFT);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt       <= 32'h0;
            halves    <= 7'h0;
            half_tick <= 1'b0;
            min_tick  <= 1'b0;
            near_roll <= 1'b0;
        end else if (!run) begin
            cnt       <= 32'h0;
            halves    <= 7'h0;
            half_tick <= 1'b0;
            min_tick  <= 1'b0;
            near_roll <= 1'b0;
        end else begin
            half_tick <= (cnt == limit - 32'h1);
            min_tick  <= (cnt == limit - 32'h1) && last_half;
            // Ripple window before the second boundary
            near_roll <= halves[0] && (cnt >= limit - 32'(ROLL_WIN_CYC));
            if (cnt >= limit - 32'h1) begin
                cnt    <= 32'h0;
                halves <= last_half ? 7'h0 : halves + 7'h1;
            end else begin
                cnt <= cnt + 32'h1;
            end
        end
    end
endmodule : clock_calendar_unit_tick_gen
`default_nettype wire

// *** core/clock_calendar_unit_value_store.sv ***
// Time value pairs behind the pointer-addressed window.
// Assumes write strobes are already gated by the unlock bit.
`timescale 1ns/1ns
`default_nettype none
module clock_calendar_unit_value_store
    import clock_calendar_unit_pkg::*;
(
    input wire logic    pclk,    // Clock
    input wire logic    presetn, // Power-on reset
    clock_calendar_unit_win_if.store   win      // Window port
);
    logic [15:0] val [4];
    localparam logic [1:0] PTR_RSV = 2'h3;

    // --------------------------------------------------------------
    // Storage: 0 min/sec, 1 wday/hour, 2 month/day, 3 -/year
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) begin
                val[i] <= 16'h0000;
            end
        end else begin
            if (win.wr_lo) begin
                val[win.ptr][7:0] <= win.wdata[7:0];
            end
            // Reserved high byte stays zero
            if (win.wr_hi && win.ptr != PTR_RSV) begin
                val[win.ptr][15:8] <= win.wdata[15:8];
            end
        end
    end

    assign win.rdata = val[win.ptr];
endmodule : clock_calendar_unit_value_store
`default_nettype wire

// *** core/clock_calendar_unit_win_if.sv ***
// Link between the register front end and the time value storage.
// Assumes both ends share pclk.
`timescale 1ns/1ns
`default_nettype none
interface clock_calendar_unit_win_if;
    logic [1:0]  ptr;
    logic [15:0] wdata;
    logic        wr_lo;
    logic        wr_hi;
    logic [15:0] rdata;
    modport ctrl  (output ptr, wdata, wr_lo, wr_hi, input rdata);
    modport store (input ptr, wdata, wr_lo, wr_hi, output rdata);
endinterface : clock_calendar_unit_win_if
`default_nettype wire

// *** sim/clock_calendar_unit_cfg_top_tb_top.sv ***
// Self-checking bench for the configuration register block over APB.
// Assumes clock_calendar_unit_pkg offsets and a half-second shortened to HC cycles.
`timescale 1ns/1ns
`default_nettype none
module clock_calendar_unit_cfg_top_tb_top
    import clock_calendar_unit_pkg::*;
;
    localparam int HC = 200;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        clk_out;
    logic        module_run;
    logic        last_err;
    logic [31:0] rv;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    clock_calendar_unit_cfg_top #(.HALF_CYCLES(HC)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .clk_out(clk_out), .module_run(module_run)
    );

    always #5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    // --------------------------------------------------------------
    // Bus and compare helpers
    // --------------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Back-to-back keeps the bus up; otherwise one idle cycle follows
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input bit more);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) cmp("pready", 32'h1, 32'h0);
        rv       = prdata;
        last_err = pslverr;
        if (!more) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h3,
                      input bit more = 1'b0);
        apb(1'b1, a, d, s, more);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 4'h0, 1'b0);
    endtask : rd

    task automatic wait_sig(ref logic sig, input logic want, input int lim);
        int n;
        n = 0;
        while (sig !== want && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim) cmp("wait", {31'h0, want}, {31'h0, sig});
    endtask : wait_sig

    // Key pair left on the bus so the next write follows at once
    task automatic unlock();
        wr(OFS_KEY, {24'h0, KEY_FIRST}, 4'h1, 1'b1);
        wr(OFS_KEY, {24'h0, KEY_SECOND}, 4'h1, 1'b1);
    endtask : unlock

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset_bus();
        rd(OFS_CFG);
        cmp("cfg reset", {16'h0, CFG_RESET}, rv);
        cmp("slverr mapped", 32'h0, {31'h0, last_err});
        rd(8'h40);
        cmp("unmapped data", 32'h0, rv);
        cmp("unmapped err", 32'h1, {31'h0, last_err});
    endtask : t_reset_bus

    task automatic t_fields();
        wr(OFS_CFG, 32'h0000_FFFF);
        rd(OFS_CFG);
        cmp("cfg fields", 32'h0000_07FF, rv);
        cmp("run locked", 32'h0, {31'h0, module_run});
        cmp("pin idle", 32'h0, {31'h0, clk_out});
        for (int i = 0; i < 4; i++) begin
            rd(OFS_WINDOW);
            rd(OFS_CFG);
            cmp("ptr after read", (i < 3) ? 2 - i : 0, {30'h0, rv[9:8]});
        end
    endtask : t_fields

    task automatic t_window();
        logic [7:0] b;
        logic [1:0] q;
        wr(OFS_KEY, 32'h55, 4'h1, 1'b1);
        wr(OFS_KEY, 32'hAA, 4'h1);
        repeat (8) @(posedge pclk);
        wr(OFS_CFG, 32'h2000);
        rd(OFS_CFG);
        cmp("late key", 32'h0, rv);
        unlock();
        wr(OFS_CFG, 32'h2000);
        rd(OFS_CFG);
        cmp("unlocked", 32'h2000, rv);
        wr(OFS_CFG, 32'hA400);
        rd(OFS_CFG);
        cmp("enabled", 32'hA400, rv & 32'hFFFF_E7FF);
        cmp("run", 32'h1, {31'h0, module_run});
        for (int p = 0; p < 4; p++) begin
            b = 8'(p);
            q = 2'(p);
            wr(OFS_CFG, 32'hA400 | {22'h0, q, 8'h00});
            wr(OFS_WINDOW, {16'h0, 8'h10 + b, 8'h20 + b});
            rd(OFS_CFG);
            cmp("ptr after write", (p > 0) ? p - 1 : 0, {30'h0, rv[9:8]});
            wr(OFS_CFG, 32'hA400 | {22'h0, q, 8'h00});
            rd(OFS_WINDOW);
            cmp("window", {16'h0, (p == 3) ? {8'h00, 8'h23} : {8'h10 + b, 8'h20 + b}}, rv);
        end
        wr(OFS_CFG, 32'h8500);
        wr(OFS_WINDOW, 32'hFFFF);
        wr(OFS_CFG, 32'h8500);
        rd(OFS_WINDOW);
        cmp("locked window", 32'h1121, rv);
        cmp("run kept", 32'h1, {31'h0, module_run});
    endtask : t_window

    task automatic t_roll();
        logic [31:0] a;
        int          i;
        wr(OFS_CFG, 32'hA400);
        i = 0;
        do begin
            rd(OFS_CFG);
            i++;
        end while (rv[12] !== 1'b1 && i < 600);
        cmp("roll set", 32'h1, {31'h0, rv[12]});
        rd(OFS_WINDOW);
        a = rv;
        rd(OFS_WINDOW);
        cmp("double read", a, rv);
        rd(OFS_STATUS);
        cmp("roll event", 32'h4, rv & 32'h4);
        i = 0;
        do begin
            rd(OFS_CFG);
            i++;
        end while (rv[12] !== 1'b0 && i < 20);
        cmp("roll clear", 32'h0, {31'h0, rv[12]});
    endtask : t_roll

    task automatic t_half();
        logic h;
        wr(OFS_ENABLE, 32'h1);
        wr(OFS_CLEAR, 32'h7);
        @(posedge pclk);
        wait_sig(irq, 1'b1, 3 * HC);
        rd(OFS_STATUS);
        cmp("half event", 32'h1, rv & 32'h1);
        rd(OFS_CFG);
        h = rv[11];
        cmp("pin follows half", {31'h0, h}, {31'h0, clk_out});
        repeat (HC) @(posedge pclk);
        rd(OFS_CFG);
        cmp("half toggled", {31'h0, ~h}, {31'h0, rv[11]});
        wr(OFS_CLEAR, 32'h1);
        @(posedge pclk);
        cmp("irq cleared", 32'h0, {31'h0, irq});
        wr(OFS_ENABLE, 32'h0);
        repeat (HC + 10) @(posedge pclk);
        cmp("irq masked", 32'h0, {31'h0, irq});
        rd(OFS_STATUS);
        cmp("status sticky", 32'h1, rv & 32'h1);
        unlock();
        wr(OFS_CFG, 32'hA400);
        wait_sig(clk_out, 1'b0, 2 * HC);
        wait_sig(clk_out, 1'b1, 2 * HC);
        wr(OFS_WINDOW, 32'h5, 4'h1);
        rd(OFS_CFG);
        cmp("half cleared", 32'h0, {31'h0, rv[11]});
    endtask : t_half

    // Minute to minute spans 120 halves plus the signed trim
    task automatic t_trim();
        int t0;
        wr(OFS_CFG, 32'hA4FF);
        wr(OFS_ENABLE, 32'h2);
        wr(OFS_CLEAR, 32'h2);
        @(posedge pclk);
        wait_sig(irq, 1'b1, HALVES_PER_MIN * HC + 100);
        t0 = cyc;
        wr(OFS_CLEAR, 32'h2);
        @(posedge pclk);
        wait_sig(irq, 1'b1, HALVES_PER_MIN * HC + 100);
        cmp("minute length", HALVES_PER_MIN * HC - 4, cyc - t0);
    endtask : t_trim

    task automatic t_disable();
        unlock();
        wr(OFS_CFG, 32'h2000);
        wr(OFS_CFG, 32'h0000);
        cmp("run off", 32'h0, {31'h0, module_run});
        cmp("pin off", 32'h0, {31'h0, clk_out});
        wr(OFS_CLEAR, 32'h7);
        repeat (2 * HC) @(posedge pclk);
        rd(OFS_STATUS);
        cmp("no ticks", 32'h0, rv & 32'h7);
    endtask : t_disable

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_bus();
        t_fields();
        t_window();
        t_roll();
        t_half();
        t_trim();
        t_disable();
        conclude();
    end

    initial begin
        #800_000;
        cmp("watchdog", 32'h0, 32'h1);
        conclude();
    end
endmodule : clock_calendar_unit_cfg_top_tb_top
`default_nettype wire
